/* File: rtl/dfird_pkg.sv */
package dfird_pkg;
  // dfi word layout at the 4:1 ratio
  localparam int PHASES = 4;
  localparam int BL = 8;
  localparam int BEAT_W = 32;
  localparam int PHASE_W = 64;
  localparam int WORD_W = 256;
  localparam int X16_W = 16;
  // advertised latencies in dfi clocks, internal delays included
  localparam int TRDDATA_EN = 4;
  localparam int TPHY_RDLAT = 12;
  localparam logic [7:0] TRDDATA_EN_CYC = 8'(TRDDATA_EN);
  localparam logic [7:0] TPHY_RDLAT_CYC = 8'(TPHY_RDLAT);
  // outstanding read tracking
  localparam int TS_W = 8;
  localparam int OUT_DEPTH = 4;
  localparam logic [2:0] OUT_FULL = 3'h4;
  localparam logic [2:0] BEAT_LAST = 3'h7;
  localparam logic [2:0] PH_BURST = 3'h4;
  // reset values
  localparam logic [TS_W-1:0] TS_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;

  typedef struct packed {
    logic valid;
    logic [BEAT_W-1:0] dq;
  } dfird_beat_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } dfird_word_t;

  typedef enum logic [1:0] {
    DFIRD_IDLE = 2'b01,
    DFIRD_BURST = 2'b10
  } dfird_state_t;
endpackage : dfird_pkg

/* File: rtl/dfird_read_path.sv */
`timescale 1ns/1ns
module dfird_read_path (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_x16,
  input wire logic [dfird_pkg::PHASES-1:0] dfi_rddata_en,
  input wire logic ctrl_rd_ready,
  input wire dfird_pkg::dfird_beat_t dq_beat,
  output logic dq_beat_ready,
  output logic phy_rd_issue,
  output logic [7:0] phy_trddata_en,
  output logic [7:0] phy_rdlat,
  output logic [dfird_pkg::WORD_W-1:0] dfi_rddata,
  output logic dfi_rddata_valid,
  output logic rd_late,
  output logic rd_overflow
);

  // phase accounting of the enable
  logic [2:0] ph_acc_r, ph_acc_nxt;
  logic [2:0] ph_pop;
  logic burst_start;
  logic issue_r, issue_nxt;

  always_comb begin
    ph_pop = 3'h0;
    for (int i = 0; i < dfird_pkg::PHASES; i++) begin
      ph_pop = ph_pop + {2'b00, dfi_rddata_en[i]};
    end
    // a burst begins at the first enabled phase after a full group
    if (ph_acc_r == dfird_pkg::CNT_RST) begin
      burst_start = (ph_pop != dfird_pkg::CNT_RST);
    end else begin
      burst_start = ((ph_acc_r + ph_pop) > dfird_pkg::PH_BURST);
    end
    ph_acc_nxt = (ph_acc_r + ph_pop) & 3'h3;
    issue_nxt = burst_start;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_acc_r <= dfird_pkg::CNT_RST;
      issue_r <= 1'b0;
    end else begin
      ph_acc_r <= ph_acc_nxt;
      issue_r <= issue_nxt;
    end
  end

  // beat assembler: eight dram beats form one dfi word
  dfird_pkg::dfird_state_t st_r, st_nxt;
  logic [2:0] beat_r, beat_nxt;
  logic [dfird_pkg::BEAT_W-1:0] slot_r [dfird_pkg::BL];
  logic [dfird_pkg::WORD_W-1:0] word_packed;
  logic word_done;
  logic beat_take;

  assign beat_take = dq_beat.valid & dq_beat_ready;

  generate
    for (genvar b = 0; b < dfird_pkg::BL; b++) begin : g_slot
      // each slot catches its own beat of the burst
      always_ff @(posedge clk) begin
        if (rst) begin
          slot_r[b] <= 32'h0000_0000;
        end else if (beat_take && beat_r == 3'(b)) begin
          slot_r[b] <= dq_beat.dq;
        end
      end
      // beats 2p and 2p+1 share phase p in x32; x16 packs them into 32-bit lane p and keeps the upper half zero
      if (b < dfird_pkg::BL / 2) begin : g_lo
        assign word_packed[b*dfird_pkg::BEAT_W +: dfird_pkg::BEAT_W] =
          cfg_x16 ? {slot_r[2*b+1][dfird_pkg::X16_W-1:0],
                     slot_r[2*b][dfird_pkg::X16_W-1:0]}
                  : slot_r[b];
      end else begin : g_hi
        assign word_packed[b*dfird_pkg::BEAT_W +: dfird_pkg::BEAT_W] =
          cfg_x16 ? 32'h0000_0000 : slot_r[b];
      end
    end
  endgenerate

  // assembler state and beat counter
  always_comb begin
    st_nxt = st_r;
    beat_nxt = beat_r;
    case (st_r)
      dfird_pkg::DFIRD_IDLE: begin
        if (beat_take) begin
          st_nxt = dfird_pkg::DFIRD_BURST;
          beat_nxt = 3'h1;
        end
      end
      dfird_pkg::DFIRD_BURST: begin
        if (beat_take) begin
          beat_nxt = beat_r + 3'h1;
          if (beat_r == dfird_pkg::BEAT_LAST) begin
            st_nxt = dfird_pkg::DFIRD_IDLE;
            beat_nxt = 3'h0;
          end
        end
      end
      default: begin
        st_nxt = dfird_pkg::DFIRD_IDLE;
        beat_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= dfird_pkg::DFIRD_IDLE;
      beat_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      beat_r <= beat_nxt;
    end
  end

  // the word is complete one cycle after the last beat lands
  logic last_r, last_nxt;
  assign last_nxt = beat_take && (beat_r == dfird_pkg::BEAT_LAST);
  assign word_done = last_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      last_r <= 1'b0;
    end else begin
      last_r <= last_nxt;
    end
  end

  // two-entry buffer, head register drives the dfi outputs
  dfird_pkg::dfird_word_t head_r, head_nxt, tail_r, tail_nxt;
  logic ready_r, ready_nxt;
  logic ovf_r, ovf_nxt;
  logic pop;

  assign pop = head_r.valid & ctrl_rd_ready;

  always_comb begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    ovf_nxt = ovf_r;
    if (pop) begin
      head_nxt = tail_r;
      tail_nxt.valid = 1'b0;
    end
    if (word_done) begin
      if (!head_nxt.valid) begin
        head_nxt = '{valid: 1'b1, data: word_packed};
      end else if (!tail_nxt.valid) begin
        tail_nxt = '{valid: 1'b1, data: word_packed};
      end else begin
        ovf_nxt = 1'b1;  // no free entry: the completed word is dropped
      end
    end
    // stall beats while the buffer has no room for a whole word
    ready_nxt = !(head_nxt.valid && tail_nxt.valid);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      ready_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      ready_r <= ready_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // outstanding reads: enable time stamps checked against the limit
  logic [dfird_pkg::TS_W-1:0] ts_r, ts_nxt;
  logic [dfird_pkg::TS_W-1:0] stamp_r [dfird_pkg::OUT_DEPTH];
  logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [2:0] outst_r, outst_nxt;
  logic [dfird_pkg::TS_W-1:0] elapsed;
  logic late_r, late_nxt;
  logic push;

  assign push = burst_start && (outst_r != dfird_pkg::OUT_FULL);

  always_comb begin
    ts_nxt = ts_r + 8'h01;
    wp_nxt = push ? wp_r + 2'h1 : wp_r;
    rp_nxt = (pop && outst_r != 3'h0) ? rp_r + 2'h1 : rp_r;
    outst_nxt = outst_r + {2'b00, push} - {2'b00, pop && outst_r != 3'h0};
    elapsed = ts_r - stamp_r[rp_r];
    late_nxt = late_r;
    if (outst_r != 3'h0 && elapsed > dfird_pkg::TPHY_RDLAT_CYC) begin
      late_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ts_r <= dfird_pkg::TS_RST;
      wp_r <= 2'h0;
      rp_r <= 2'h0;
      outst_r <= dfird_pkg::CNT_RST;
      late_r <= 1'b0;
      for (int i = 0; i < dfird_pkg::OUT_DEPTH; i++) begin
        stamp_r[i] <= dfird_pkg::TS_RST;
      end
    end else begin
      ts_r <= ts_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      outst_r <= outst_nxt;
      late_r <= late_nxt;
      if (push) begin
        stamp_r[wp_r] <= ts_r;
      end
    end
  end

  // advertised latencies, fixed
  logic [7:0] trd_r, rdlat_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      trd_r <= 8'h00;
      rdlat_r <= 8'h00;
    end else begin
      trd_r <= dfird_pkg::TRDDATA_EN_CYC;
      rdlat_r <= dfird_pkg::TPHY_RDLAT_CYC;
    end
  end

  // outputs straight from flops
  assign dq_beat_ready = ready_r;
  assign phy_rd_issue = issue_r;
  assign phy_trddata_en = trd_r;
  assign phy_rdlat = rdlat_r;
  assign dfi_rddata = head_r.data;
  assign dfi_rddata_valid = head_r.valid;
  assign rd_late = late_r;
  assign rd_overflow = ovf_r;

  // checks
  a_issue_follows_en: assert property (
    @(posedge clk) disable iff (rst) burst_start |=> phy_rd_issue)
    else $error("enable burst not forwarded");
  a_word_after_last: assert property (
    @(posedge clk) disable iff (rst) last_nxt
    && !(head_r.valid && tail_r.valid) |=> ##1 dfi_rddata_valid)
    else $error("completed burst not presented");
  a_valid_in_time: assert property (
    @(posedge clk) disable iff (rst) outst_r != 3'h0
    && elapsed > dfird_pkg::TPHY_RDLAT_CYC |=> rd_late)
    else $error("late read not flagged");
  a_lat_advertised: assert property (
    @(posedge clk) disable iff (rst) !$past(rst)
    |-> phy_rdlat == dfird_pkg::TPHY_RDLAT_CYC
    && phy_trddata_en == dfird_pkg::TRDDATA_EN_CYC)
    else $error("advertised latency wrong");
  a_x16_upper_zero: assert property (
    @(posedge clk) disable iff (rst) cfg_x16 && $stable(cfg_x16)
    && $rose(dfi_rddata_valid) |-> dfi_rddata[255:128] == '0)
    else $error("x16 word has upper bits set");
  a_x32_phase_map: assert property (
    @(posedge clk) disable iff (rst) !cfg_x16 && word_done
    && !head_r.valid |=> dfi_rddata[63:0] ==
    {$past(slot_r[1]), $past(slot_r[0])})
    else $error("phase 0 packing wrong");
  a_phase_count: assert property (
    @(posedge clk) disable iff (rst) dfi_rddata_en == 4'hf
    && ph_acc_r == 3'h0 |=> ph_acc_r == 3'h0 && phy_rd_issue)
    else $error("full phase group miscounted");
  a_split_once: assert property (
    @(posedge clk) disable iff (rst) ph_acc_r == 3'h1
    && dfi_rddata_en == 4'h7 |=> ph_acc_r == 3'h0 && !phy_rd_issue)
    else $error("split phase group counted twice");
  a_stall_holds: assert property (
    @(posedge clk) disable iff (rst) dfi_rddata_valid && !ctrl_rd_ready
    |=> dfi_rddata_valid && $stable(dfi_rddata))
    else $error("stalled word changed");

  c_read_done: cover property (@(posedge clk) disable iff (rst)
    phy_rd_issue ##[1:20] dfi_rddata_valid && ctrl_rd_ready);
  c_split_enable: cover property (@(posedge clk) disable iff (rst)
    dfi_rddata_en == 4'h8 ##1 dfi_rddata_en == 4'h7);
  c_buffer_full: cover property (@(posedge clk) disable iff (rst)
    dfi_rddata_valid && !dq_beat_ready);

endmodule : dfird_read_path

/* File: tb/dfird_ctrl_model.sv */
`timescale 1ns/1ns
// controller side: raises the enable after a read and takes words
module dfird_ctrl_model (
  input wire logic clk,
  input wire logic rd_cmd,
  input wire logic stall,
  input wire logic slow,
  input wire logic split,
  input wire logic [dfird_pkg::WORD_W-1:0] rd_data,
  input wire logic rd_valid,
  output logic [dfird_pkg::PHASES-1:0] rd_en = 4'h0,
  output logic rd_ready = 1'b0
);
  logic [dfird_pkg::TRDDATA_EN-1:0] cmd_r = 4'h0;
  logic tog_r = 1'b0;
  logic split_r = 1'b0;
  logic [dfird_pkg::WORD_W-1:0] got_q[$];
  // command delay line and capture of returned words
  always @(posedge clk) begin
    cmd_r <= {cmd_r[dfird_pkg::TRDDATA_EN-2:0], rd_cmd};
    if (rd_valid === 1'b1 && rd_ready) begin
      got_q.push_back(rd_data);
    end
  end
  // four phases per bl8 burst, in one clock or split over two; ready may lag
  always @(negedge clk) begin
    if (cmd_r[dfird_pkg::TRDDATA_EN-1]) begin
      rd_en <= split ? 4'h8 : 4'hf;
    end else begin
      rd_en <= split_r ? 4'h7 : 4'h0;
    end
    split_r <= cmd_r[dfird_pkg::TRDDATA_EN-1] && split;
    tog_r <= ~tog_r;
    rd_ready <= !stall && !(slow && tog_r);
  end
endmodule : dfird_ctrl_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  localparam int W = dfird_pkg::WORD_W;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_x16 = 1'b0;
  logic rd_cmd = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic split = 1'b0;
  logic [3:0] rd_en;
  logic rd_ready, dq_beat_ready, phy_rd_issue, rd_valid, rd_late, rd_ovf;
  logic [7:0] trd, rdlat;
  logic [W-1:0] rd_data;
  dfird_pkg::dfird_beat_t dq_beat = '{1'b0, 32'h0000_0000};
  logic [31:0] lfsr = 32'h0000_1058;
  logic [W-1:0] exp_q[$];
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int issues = 0;

  dfird_read_path dut (.clk(clk), .rst(rst), .cfg_x16(cfg_x16),
    .dfi_rddata_en(rd_en), .ctrl_rd_ready(rd_ready), .dq_beat(dq_beat),
    .dq_beat_ready(dq_beat_ready), .phy_rd_issue(phy_rd_issue),
    .phy_trddata_en(trd), .phy_rdlat(rdlat), .dfi_rddata(rd_data),
    .dfi_rddata_valid(rd_valid), .rd_late(rd_late), .rd_overflow(rd_ovf));
  dfird_ctrl_model ctrl (.clk(clk), .rd_cmd(rd_cmd), .stall(stall),
    .slow(slow), .split(split), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_en(rd_en), .rd_ready(rd_ready));

  // clock and cycle/issue counters
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (phy_rd_issue === 1'b1) issues <= issues + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [W-1:0] seen,
    input logic [W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic hang;
    errors++;
    report_and_stop();
  endtask : hang

  // one read: command, enable after the model's delay, eight dram beats
  task automatic burst(input logic chk_lat);
    logic [W-1:0] w;
    int t0;
    int n;
    w = 256'h0;
    @(negedge clk);
    rd_cmd = 1'b1;
    @(negedge clk);
    rd_cmd = 1'b0;
    for (n = 0; n < 20 && rd_en === 4'h0; n++) @(negedge clk);
    if (n == 20) hang();
    t0 = cyc;
    for (int b = 0; b < 8; b++) begin
      lfsr = lfsr_next(lfsr);
      for (n = 0; n < 80; n++) begin
        @(negedge clk);
        if (dq_beat_ready === 1'b1) break;
        dq_beat.valid = 1'b0;
      end
      if (n == 80) hang();
      dq_beat = '{1'b1, lfsr};
      if (cfg_x16) w[16*b+:16] = lfsr[15:0];
      else w[32*b+:32] = lfsr;
    end
    @(negedge clk);
    dq_beat.valid = 1'b0;
    exp_q.push_back(w);
    if (chk_lat) begin
      for (n = 0; n < 30 && rd_valid !== 1'b1; n++) @(negedge clk);
      check("latency", W'(cyc - t0 <= dfird_pkg::TPHY_RDLAT), W'(1));
    end
  endtask : burst

  // main sequence: directed widths, random traffic, buffer fill and drain
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("trddata_en", W'(trd), W'(dfird_pkg::TRDDATA_EN_CYC));
    check("rdlat", W'(rdlat), W'(dfird_pkg::TPHY_RDLAT_CYC));
    check("beat ready", W'(dq_beat_ready), W'(1));
    burst(1'b1);
    cfg_x16 = 1'b1;
    burst(1'b1);
    check("late early", W'(rd_late), W'(0));
    slow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      // let the previous word be packed before the width changes
      @(negedge clk);
      cfg_x16 = lfsr[7];
      split = lfsr[3] || i == 0;
      burst(1'b0);
    end
    // drain the last slow word so that the stall fills exactly two entries
    repeat (4) @(negedge clk);
    slow = 1'b0;
    split = 1'b0;
    stall = 1'b1;
    burst(1'b0);
    burst(1'b0);
    repeat (40) @(negedge clk);
    check("full", W'(dq_beat_ready), W'(0));
    stall = 1'b0;
    for (int n = 0; n < 200 && ctrl.got_q.size() < exp_q.size(); n++)
      @(negedge clk);
    check("words", W'(ctrl.got_q.size()), W'(exp_q.size()));
    foreach (exp_q[i]) check("word", ctrl.got_q[i], exp_q[i]);
    check("issues", W'(issues), W'(10));
    check("overflow", W'(rd_ovf), W'(0));
    check("late", W'(rd_late), W'(1));
    report_and_stop();
  end
endmodule : tb_top
